// file: hw/sipc_pkg.sv
package sipc_pkg;

  // Logic clock period at the 100 MHz simulation rate.
  localparam int CLK_PERIOD_NS      = 10;

  // Idle timeout step and range.
  localparam int IDLE_STEP_TIME_US  = 4096;
  localparam int IDLE_TIME_MAX_MS   = 33000;
  localparam int IDLE_STEPS_W       = 13;
  localparam logic [IDLE_STEPS_W-1:0] IDLE_STEPS_MIN = 13'h0001;
  localparam logic [IDLE_STEPS_W-1:0] IDLE_STEPS_MAX =
    IDLE_STEPS_W'(IDLE_TIME_MAX_MS * 1000 / IDLE_STEP_TIME_US);

  // A step is a least time, so it rounds up.
  localparam int STEP_TIME_NS       = IDLE_STEP_TIME_US * 1000;
  localparam int STEP_CYCLES        = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Power-on delay counter and register initialisation are longest times.
  localparam int POR_DELAY_TIME_US  = 160;
  localparam int POR_DELAY_CYCLES   = POR_DELAY_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int INIT_TIME_MS       = 14;
  localparam int INIT_CYCLES        = INIT_TIME_MS * 1000000 / CLK_PERIOD_NS;

  // The oscillator needs at least this long to become stable after wake.
  localparam int OSC_ON_TIME_US     = 5;
  localparam int OSC_ON_CYCLES      = (OSC_ON_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Oscillator frequency select: 1 selects 8 MHz, 0 selects 4 MHz.
  localparam logic FREQ_SEL_8M      = 1'b1;
  localparam logic FREQ_SEL_RESET   = FREQ_SEL_8M;

  localparam int SYNC_STAGES        = 3;
  localparam int BUS_LINES          = 2;

  typedef enum logic [2:0] {
    ST_POR    = 3'b000,
    ST_INIT   = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_SLEEP  = 3'b011,
    ST_WAKE   = 3'b100
  } sipc_state_e;

endpackage : sipc_pkg

// file: hw/sipc_step_timer.sv
`timescale 1ns/10ps

module sipc_step_timer
  import sipc_pkg::*;
#(
  parameter int STEP_CYCLES_P = STEP_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic restart_in,
  output logic      tick_out
);

  localparam int CNT_W = $clog2(STEP_CYCLES_P + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STEP_CYCLES_P - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  logic [CNT_W-1:0] cnt_reg;

  // A restart drops any partial step, so a full step always follows bus activity.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_reg <= CNT_ZERO;
    end else if (restart_in || cnt_reg == CNT_LAST) begin
      cnt_reg <= CNT_ZERO;
    end else begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  assign tick_out = !restart_in && (cnt_reg == CNT_LAST);

endmodule : sipc_step_timer

// file: hw/sipc_power_ctrl.sv
`timescale 1ns/10ps

// Contract
// RQ1 - Device is only a bus slave; it samples the bus lines and never drives them.
// RQ2 - All internal logic runs from the on-chip oscillator clock.
// RQ3 - A nonvolatile setting selects a 4 MHz or 8 MHz oscillator rate.
// RQ4 - Sleep only after both lines high and nothing busy for the whole idle time.
// RQ5 - Idle time ranges 4.096 ms to 33 s in 4.096 ms steps.
// RQ6 - The host may rewrite the idle time over the serial bus.
// RQ7 - In sleep the internal oscillator is stopped.
// RQ8 - Either bus line going low ends sleep and returns to active mode.
// RQ9 - Power-on reset forces every internal register to its initial value.
// RQ10 - After power-on reset the idle time is its 33 s maximum.
// RQ11 - The host must not change the idle time before initialisation ends.
// RQ12 - A delay counter after supply rise keeps the device in reset until done.
// RQ13 - The idle timer counts steps and restarts on bus low or busy.
// RQ14 - On wake, logic stays idle until the oscillator is stable.
module sipc_power_ctrl
  import sipc_pkg::*;
#(
  parameter int STEP_CYCLES_P      = STEP_CYCLES,
  parameter int POR_DELAY_CYCLES_P = POR_DELAY_CYCLES,
  parameter int INIT_CYCLES_P      = INIT_CYCLES,
  parameter int OSC_ON_CYCLES_P    = OSC_ON_CYCLES
) (
  input  wire logic                    CLOCK_IN,
  input  wire logic                    ARST_N_IN,
  input  wire logic                    SCL_IN,
  input  wire logic                    SDA_IN,
  input  wire logic                    BUSY_IN,
  input  wire logic                    OSC_8M_SEL_IN,
  input  wire logic [IDLE_STEPS_W-1:0] IDLE_STEPS_IN,
  input  wire logic                    IDLE_STEPS_WE_IN,
  output logic                         OSC_EN_OUT,
  output logic                         OSC_FREQ_8M_OUT,
  output logic                         CORE_RST_N_OUT,
  output logic                         CORE_HOLD_OUT,
  output logic                         SLEEP_OUT,
  output logic                         INIT_DONE_OUT,
  output logic [IDLE_STEPS_W-1:0]      IDLE_STEPS_OUT
);

  localparam int WAIT_W = $clog2(POR_DELAY_CYCLES_P + INIT_CYCLES_P + OSC_ON_CYCLES_P + 1);
  localparam logic [WAIT_W-1:0] WAIT_POR  = WAIT_W'(POR_DELAY_CYCLES_P - 1);
  localparam logic [WAIT_W-1:0] WAIT_INIT = WAIT_W'(INIT_CYCLES_P - 1);
  localparam logic [WAIT_W-1:0] WAIT_OSC  = WAIT_W'(OSC_ON_CYCLES_P - 1);
  localparam logic [WAIT_W-1:0] WAIT_ZERO = '0;
  localparam logic [IDLE_STEPS_W-1:0] IDLE_ZERO = '0;
  localparam logic [IDLE_STEPS_W-1:0] IDLE_ONE  = 13'h0001;

  sipc_state_e                state_reg;
  sipc_state_e                state_next;
  logic [WAIT_W-1:0]          wait_cnt_reg;
  logic                       wait_done;
  logic [IDLE_STEPS_W-1:0]    idle_cnt_reg;
  logic [IDLE_STEPS_W-1:0]    idle_steps_reg;
  logic [BUS_LINES-1:0]       pin_raw;
  logic [BUS_LINES-1:0]       line_reg;
  logic                       bus_idle;
  logic                       bus_low;
  logic                       timer_restart;
  logic                       step_tick;
  logic                       idle_expire;
  logic                       wake_req;

  // Only the two lines are sampled; this block never drives the bus.
  assign pin_raw = {SCL_IN, SDA_IN}; // RQ1

  // Each line passes three flops; a level is taken once stages two and three agree.
  genvar gi;
  generate
    for (gi = 0; gi < BUS_LINES; gi++) begin : g_sync
      logic [SYNC_STAGES-1:0] sync_reg;
      always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
          sync_reg <= '1;
        end else begin
          sync_reg <= {sync_reg[SYNC_STAGES-2:0], pin_raw[gi]};
        end
      end
      always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
          line_reg[gi] <= 1'b1;
        end else if (sync_reg[1] == sync_reg[2]) begin
          line_reg[gi] <= sync_reg[2];
        end
      end
    end
  endgenerate

  assign bus_idle = &line_reg;
  assign bus_low  = !bus_idle;

  assign timer_restart = (state_reg != ST_ACTIVE) || bus_low || BUSY_IN; // RQ13

  sipc_step_timer #(
    .STEP_CYCLES_P (STEP_CYCLES_P)
  ) u_step_timer (
    .clk_in     (CLOCK_IN),
    .arst_n_in  (ARST_N_IN),
    .restart_in (timer_restart),
    .tick_out   (step_tick)
  );

  // The last step of the programmed count ends the idle period.
  assign idle_expire = step_tick &&
                       (IDLE_STEPS_W'(idle_cnt_reg + IDLE_ONE) >= idle_steps_reg); // RQ4

  assign wait_done = (wait_cnt_reg == WAIT_ZERO);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_POR: begin
        if (wait_done) state_next = ST_INIT; // RQ12
      end
      ST_INIT: begin
        if (wait_done) state_next = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (idle_expire) state_next = ST_SLEEP; // RQ4
      end
      ST_SLEEP: begin
        if (bus_low) state_next = ST_WAKE; // RQ8
      end
      ST_WAKE: begin
        if (wait_done) state_next = ST_ACTIVE; // RQ14
      end
      default: begin
        state_next = ST_POR;
      end
    endcase
  end

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state_reg <= ST_POR; // RQ9
    end else begin
      state_reg <= state_next;
    end
  end

  // One down-counter serves the power-on delay, initialisation and oscillator start.
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      wait_cnt_reg <= WAIT_POR; // RQ12
    end else if (state_next != state_reg) begin
      unique case (state_next)
        ST_INIT: wait_cnt_reg <= WAIT_INIT;
        ST_WAKE: wait_cnt_reg <= WAIT_OSC; // RQ14
        default: wait_cnt_reg <= WAIT_ZERO;
      endcase
    end else if (!wait_done) begin
      wait_cnt_reg <= wait_cnt_reg - WAIT_W'(1);
    end
  end

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      idle_cnt_reg <= IDLE_ZERO;
    end else if (timer_restart) begin
      idle_cnt_reg <= IDLE_ZERO; // RQ13
    end else if (step_tick) begin
      idle_cnt_reg <= IDLE_STEPS_W'(idle_cnt_reg + IDLE_ONE); // RQ13
    end
  end

  // Writes before initialisation ends are dropped so the default cannot be lost.
  // Out-of-range values are clamped rather than rejected.
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      idle_steps_reg <= IDLE_STEPS_MAX; // RQ10
    end else if (IDLE_STEPS_WE_IN && INIT_DONE_OUT) begin // RQ11
      if (IDLE_STEPS_IN < IDLE_STEPS_MIN) begin
        idle_steps_reg <= IDLE_STEPS_MIN; // RQ5
      end else if (IDLE_STEPS_IN > IDLE_STEPS_MAX) begin
        idle_steps_reg <= IDLE_STEPS_MAX; // RQ5
      end else begin
        idle_steps_reg <= IDLE_STEPS_IN; // RQ6
      end
    end
  end

  // The rate setting is read from nonvolatile memory as initialisation ends.
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      OSC_FREQ_8M_OUT <= FREQ_SEL_RESET; // RQ2
    end else if (state_reg == ST_INIT && wait_done) begin
      OSC_FREQ_8M_OUT <= OSC_8M_SEL_IN; // RQ3
    end
  end

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      CORE_RST_N_OUT <= 1'b0;
      CORE_HOLD_OUT  <= 1'b1;
      SLEEP_OUT      <= 1'b0;
      INIT_DONE_OUT  <= 1'b0;
    end else begin
      CORE_RST_N_OUT <= (state_next != ST_POR); // RQ12
      // The core stays held through the power-on delay and initialisation as well.
      CORE_HOLD_OUT  <= (state_next != ST_ACTIVE); // RQ12 RQ14
      SLEEP_OUT      <= (state_next == ST_SLEEP);
      INIT_DONE_OUT  <= INIT_DONE_OUT || (state_next == ST_ACTIVE);
    end
  end

  assign IDLE_STEPS_OUT = idle_steps_reg;

  // The clock is stopped in sleep, so a low line must restart the oscillator
  // straight from the pins; the clocked wake path follows once edges return.
  assign wake_req   = SLEEP_OUT && !(SCL_IN && SDA_IN); // RQ8
  assign OSC_EN_OUT = !SLEEP_OUT || wake_req; // RQ7

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!ARST_N_IN);

  sequence init_end_s;
    state_reg == ST_INIT && wait_done;
  endsequence

  sequence wake_start_s;
    state_reg == ST_SLEEP && bus_low;
  endsequence

  sleep_entry_a: assert property ( // RQ4
    $rose(SLEEP_OUT) |-> $past(state_reg == ST_ACTIVE && bus_idle && !BUSY_IN && step_tick))
    else $error("Sleep entered without a full quiet step.");

  idle_full_a: assert property ( // RQ5
    $rose(SLEEP_OUT) |-> $past(IDLE_STEPS_W'(idle_cnt_reg + IDLE_ONE) >= idle_steps_reg))
    else $error("Sleep entered before the idle count was reached.");

  idle_range_a: assert property ( // RQ5
    idle_steps_reg >= IDLE_STEPS_MIN && idle_steps_reg <= IDLE_STEPS_MAX)
    else $error("Idle step count outside its range.");

  osc_gate_a: assert property ( // RQ7
    state_reg == ST_SLEEP && SCL_IN && SDA_IN |-> SLEEP_OUT && !OSC_EN_OUT)
    else $error("Oscillator enabled during quiet sleep.");

  wake_exit_a: assert property ( // RQ8
    wake_start_s |=> state_reg == ST_WAKE && !SLEEP_OUT && CORE_HOLD_OUT)
    else $error("Bus low in sleep did not start a wake.");

  wake_wait_a: assert property ( // RQ14
    wake_start_s |=> wait_cnt_reg == WAIT_OSC && CORE_HOLD_OUT)
    else $error("Wake did not wait for the oscillator.");

  idle_restart_a: assert property ( // RQ13
    state_reg == ST_ACTIVE && (bus_low || BUSY_IN) |=> idle_cnt_reg == IDLE_ZERO)
    else $error("Idle count not restarted by activity.");

  reset_values_a: assert property ( // RQ9
    state_reg == ST_POR |-> idle_steps_reg == IDLE_STEPS_MAX && !INIT_DONE_OUT)
    else $error("Register not at its initial value in reset.");

  init_default_a: assert property ( // RQ10
    init_end_s |=> IDLE_STEPS_OUT == IDLE_STEPS_MAX && INIT_DONE_OUT)
    else $error("Idle time not at maximum after initialisation.");

  write_block_a: assert property ( // RQ11
    !INIT_DONE_OUT && IDLE_STEPS_WE_IN |=> $stable(IDLE_STEPS_OUT))
    else $error("Idle time changed before initialisation ended.");

  por_hold_a: assert property ( // RQ12
    state_reg == ST_POR |-> !CORE_RST_N_OUT && CORE_HOLD_OUT)
    else $error("Core released during the power-on delay.");

  freq_sel_a: assert property ( // RQ3
    init_end_s |=> OSC_FREQ_8M_OUT == $past(OSC_8M_SEL_IN))
    else $error("Oscillator rate not taken from the setting.");

endmodule : sipc_power_ctrl

// file: tb/sipc_host_model.sv
`timescale 1ns/10ps

// Released lines read high through the bus pull-ups, so idle is a driven 1.
module sipc_host_model #(
  parameter int HALF_P = 6
) (
  input  wire logic clk_in,
  input  wire logic go_in,
  input  wire logic scl_only_in,
  output logic      scl_out,
  output logic      sda_out,
  output logic      busy_out
);
  initial begin
    scl_out  = 1'b1;
    sda_out  = 1'b1;
    busy_out = 1'b0;
    forever begin
      @(posedge clk_in);
      if (go_in) begin
        busy_out <= 1'b1;
        if (scl_only_in) begin
          // A lone low is held past the wake settle time, so quiet starts after wake.
          scl_out <= 1'b0;
          repeat (HALF_P) @(posedge clk_in);
        end else begin
          sda_out <= 1'b0;
          repeat (HALF_P) @(posedge clk_in);
          repeat (2) begin
            scl_out <= 1'b0;
            repeat (HALF_P) @(posedge clk_in);
            scl_out <= 1'b1;
            repeat (HALF_P) @(posedge clk_in);
          end
        end
        repeat (HALF_P) @(posedge clk_in);
        scl_out  <= 1'b1;
        sda_out  <= 1'b1;
        busy_out <= 1'b0;
      end
    end
  end
endmodule : sipc_host_model

// file: tb/testbench.sv
`timescale 1ns/10ps

module testbench;
  import sipc_pkg::*;
  localparam int STEP_P = 8;
  localparam int POR_P  = 4;
  localparam int INIT_P = 10;
  localparam int OSC_P  = 3;
  localparam int IDLE_N = 2;

  logic                    clk = 1'b0;
  logic                    arst_n = 1'b0;
  logic                    scl, sda, host_busy, osc_en, freq8, core_rst_n, hold, sleep;
  logic                    busy = 1'b0;
  logic                    sel8 = 1'b0;
  logic                    we = 1'b0;
  logic                    go = 1'b0;
  logic                    scl_only = 1'b0;
  logic                    init_done;
  logic [IDLE_STEPS_W-1:0] steps = 13'h0000;
  logic [IDLE_STEPS_W-1:0] steps_q;
  int                      miscompares = 0;
  int                      tests_run = 0;
  int                      cycles = 0;

  sipc_power_ctrl #(.STEP_CYCLES_P(STEP_P), .POR_DELAY_CYCLES_P(POR_P),
    .INIT_CYCLES_P(INIT_P), .OSC_ON_CYCLES_P(OSC_P)) uut (
    .CLOCK_IN(clk), .ARST_N_IN(arst_n), .SCL_IN(scl), .SDA_IN(sda), .BUSY_IN(busy),
    .OSC_8M_SEL_IN(sel8), .IDLE_STEPS_IN(steps), .IDLE_STEPS_WE_IN(we),
    .OSC_EN_OUT(osc_en), .OSC_FREQ_8M_OUT(freq8), .CORE_RST_N_OUT(core_rst_n),
    .CORE_HOLD_OUT(hold), .SLEEP_OUT(sleep), .INIT_DONE_OUT(init_done),
    .IDLE_STEPS_OUT(steps_q));

  sipc_host_model #(.HALF_P(6)) host (.clk_in(clk), .go_in(go), .scl_only_in(scl_only),
    .scl_out(scl), .sda_out(sda), .busy_out(host_busy));

  always #5 clk = ~clk;

  task automatic end_sim();
    if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  // The whole run needs about two hundred cycles; this only catches a hang.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [12:0] exp, input logic [12:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("BAD %s expected %0d seen %0d", nm, exp, got);
      miscompares++;
    end
  endtask : chk

  task automatic rng(input string nm, input int lo, input int hi, input int got);
    tests_run++;
    if (got < lo || got > hi) begin
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      miscompares++;
    end
  endtask : rng

  function automatic logic pick(input int w);
    case (w)
      0:       return sleep;
      1:       return hold;
      2:       return core_rst_n;
      3:       return init_done;
      default: return host_busy;
    endcase
  endfunction : pick

  task automatic count_to(input int w, input logic v, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
      @(negedge clk);
    end while (pick(w) !== v && n < 100);
  endtask : count_to

  task automatic t_reset();
    int n;
    repeat (7) @(posedge clk);
    @(negedge clk);
    chk("core_rst_n", 1'b0, core_rst_n);
    chk("hold", 1'b1, hold);
    chk("sleep", 1'b0, sleep);
    chk("init_done", 1'b0, init_done);
    chk("freq8", 1'b1, freq8);
    chk("osc_en", 1'b1, osc_en);
    chk("idle_steps", IDLE_STEPS_MAX, steps_q);
    @(posedge clk);
    arst_n <= 1'b1;
    count_to(2, 1'b1, n);
    rng("por_delay", POR_P, POR_P, n);
    chk("hold", 1'b1, hold);
    @(posedge clk);
    steps <= 13'h0005;
    we    <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    count_to(3, 1'b1, n);
    rng("init_time", INIT_P - 2, INIT_P - 2, n);
    chk("idle_steps", IDLE_STEPS_MAX, steps_q);
    chk("freq8", 1'b0, freq8);
    chk("hold", 1'b0, hold);
  endtask : t_reset

  task automatic write_chk(input logic [12:0] v, input logic [12:0] exp);
    @(posedge clk);
    steps <= v;
    we    <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    @(negedge clk);
    chk("idle_steps", exp, steps_q);
  endtask : write_chk

  task automatic t_wake(input logic only_scl, input logic use_busy);
    int n;
    @(posedge clk);
    go       <= 1'b1;
    scl_only <= only_scl;
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    chk("osc_en", 1'b1, osc_en);
    count_to(0, 1'b0, n);
    rng("wake_time", 1, 8, n);
    chk("hold", 1'b1, hold);
    count_to(1, 1'b0, n);
    rng("osc_settle", OSC_P, OSC_P + 1, n);
    count_to(4, 1'b0, n);
    if (use_busy) begin
      repeat (10) @(posedge clk);
      busy <= 1'b1;
      @(posedge clk);
      busy <= 1'b0;
      // Without the restart the quiet time would already have ended here.
      repeat (STEP_P + 1) @(posedge clk);
      @(negedge clk);
      chk("early_sleep", 1'b0, sleep);
    end
    count_to(0, 1'b1, n);
    rng("idle_wait", use_busy ? IDLE_N * STEP_P - STEP_P - 1 : IDLE_N * STEP_P + 3,
        use_busy ? IDLE_N * STEP_P - STEP_P : IDLE_N * STEP_P + 5, n);
    chk("osc_en", 1'b0, osc_en);
    chk("hold", 1'b1, hold);
  endtask : t_wake

  initial begin
    int n;
    t_reset();
    write_chk(13'h0000, IDLE_STEPS_MIN);
    write_chk(13'h1fff, IDLE_STEPS_MAX);
    write_chk(IDLE_STEPS_MAX, IDLE_STEPS_MAX);
    write_chk(13'h0002, 13'h0002);
    count_to(0, 1'b1, n);
    chk("sleep", 1'b1, sleep);
    t_wake(1'b0, 1'b0);
    t_wake(1'b1, 1'b0);
    t_wake(1'b1, 1'b1);
    end_sim();
  end
endmodule : testbench
